// ### verilog/pwmdp_pkg.sv
// Shared constants, register map and types of the PWM channel data path.
package pwmdp_pkg;

    // ==========================================================================
    // Sizes
    localparam int PWMDP_CH = 2;
    localparam int PWMDP_DW = 32;
    localparam int PWMDP_AW = 8;
    localparam int PWMDP_FIFO_DEPTH = 16;
    localparam int PWMDP_PTR_W = 4;
    localparam int PWMDP_LVL_W = 5;

    // ==========================================================================
    // Register offsets
    localparam logic [7:0] PWMDP_OFS_CTRL = 8'h00;
    localparam logic [7:0] PWMDP_OFS_STAT = 8'h04;
    localparam logic [7:0] PWMDP_OFS_DMA = 8'h08;
    localparam logic [7:0] PWMDP_OFS_P1 = 8'h10;
    localparam logic [7:0] PWMDP_OFS_V1 = 8'h14;
    localparam logic [7:0] PWMDP_OFS_FIFO = 8'h18;
    localparam logic [7:0] PWMDP_OFS_P2 = 8'h20;
    localparam logic [7:0] PWMDP_OFS_V2 = 8'h24;

    // ==========================================================================
    // Reset values
    localparam logic [31:0] PWMDP_DMA_RST = 32'h00000707;
    localparam logic [31:0] PWMDP_PERIOD_RST = 32'h00000020;
    localparam logic [31:0] PWMDP_VALUE_RST = 32'h00000000;
    localparam logic [15:0] PWMDP_CTRL_RST = 16'h0000;
    localparam logic [31:0] PWMDP_BUS_DEFAULT = 32'h00000000;

    // ==========================================================================
    // Field positions
    localparam int PWMDP_DMA_EN_BIT = 31;
    localparam int PWMDP_URG_LSB = 8;
    localparam int PWMDP_DRQ_LSB = 0;
    localparam int PWMDP_CTL_STRIDE = 8;
    localparam int PWMDP_CTL_EN = 0;
    localparam int PWMDP_CTL_MODE = 1;
    localparam int PWMDP_CTL_RPT = 2;
    localparam int PWMDP_CTL_IDLE = 3;
    localparam int PWMDP_CTL_FIFO = 5;
    localparam int PWMDP_CTL_CLR = 6;
    localparam int PWMDP_STA_FULL = 0;
    localparam int PWMDP_STA_EMPTY = 1;
    localparam int PWMDP_STA_RUN = 2;
    localparam int PWMDP_STA_LVL = 8;

    // ==========================================================================
    // Types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [PWMDP_AW-1:0] addr;
        logic [PWMDP_DW-1:0] wdata;
    } pwmdp_req_t;

    typedef struct packed {
        logic enable;
        logic output_style_select;
        logic repeat_last_word;
        logic idle_level;
        logic fifo_select;
    } pwmdp_chcfg_t;

    typedef enum logic [1:0] {
        PWMDP_OFF,
        PWMDP_NEED,
        PWMDP_RUN
    } pwmdp_state_t;

    typedef enum logic [3:0] {
        PWMDP_SEL_NONE,
        PWMDP_SEL_CTRL,
        PWMDP_SEL_STAT,
        PWMDP_SEL_DMA,
        PWMDP_SEL_P1,
        PWMDP_SEL_V1,
        PWMDP_SEL_FIFO,
        PWMDP_SEL_P2,
        PWMDP_SEL_V2
    } pwmdp_sel_t;

endpackage

// ### verilog/pwmdp_buf2.sv
// Two-entry valid/ready buffer between the shared FIFO and the channels.
`timescale 1ns/10ps
`default_nettype none
module pwmdp_buf2 #(
    parameter int W = 32
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    // ==========================================================================
    // Storage
    logic [W-1:0] mem [2];
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic push;
    logic pop;

    assign in_ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else if (clr) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) begin
                wp <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule
`default_nettype wire

// ### verilog/pwmdp_top.sv
// Two-channel pulse and serialiser data path with shared FIFO and DMA requests.
//
// Summary of operation
// - Data requests are issued only while the DMA enable bit 31 is set.
// - Bits 15:8 give the FIFO level threshold for the urgent request.
// - Bits 7:0 give the FIFO level threshold for the data request.
// - The 32-bit period register sets each channel's period, reset 32.
// - Period below 32 sends only that many leading bits of the word.
// - Period above 32 pads after the 32 data bits until period ends.
// - Pulse mode emits data-value pulses per period from the data register.
// - Serial mode shifts the data word out as the channel bitstream.
// - FIFO input writes queue words; only FIFO-select channels take them.
// - The FIFO input address is write-only and reads the bus default.
// - Sharing channels receive successive FIFO words in rotation, lowest waiting channel first.
// - Sharing channels fetch in lock-step; shorter periods wait idle.
// - Settings for channels 3 and 4 are ignored.
// - Output style bit 0 selects pulse mode, 1 serialiser; reset is pulse.
// - FIFO select high sends FIFO data, low sends the data register.
// - Serial words go out most significant bit first.
// - The idle level is driven between transfers and as tail padding.
`timescale 1ns/10ps
`default_nettype none
module pwmdp_top
    import pwmdp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire pwmdp_req_t bus_req,
    output logic [PWMDP_DW-1:0] bus_rdata,
    output logic dma_req,
    output logic dma_urgent,
    output logic [PWMDP_CH-1:0] pwm_out
);

    // ==========================================================================
    // Address decode
    function automatic pwmdp_sel_t decode(input logic [PWMDP_AW-1:0] a);
        pwmdp_sel_t s;
        unique case (a)
            PWMDP_OFS_CTRL: s = PWMDP_SEL_CTRL;
            PWMDP_OFS_STAT: s = PWMDP_SEL_STAT;
            PWMDP_OFS_DMA: s = PWMDP_SEL_DMA;
            PWMDP_OFS_P1: s = PWMDP_SEL_P1;
            PWMDP_OFS_V1: s = PWMDP_SEL_V1;
            PWMDP_OFS_FIFO: s = PWMDP_SEL_FIFO;
            PWMDP_OFS_P2: s = PWMDP_SEL_P2;
            PWMDP_OFS_V2: s = PWMDP_SEL_V2;
            // Channel 3 and 4 addresses fall here and are not decoded.
            default: s = PWMDP_SEL_NONE;
        endcase
        return s;
    endfunction

    pwmdp_sel_t sel;
    logic wr_ctrl;
    logic wr_fifo;
    logic fifo_clr;

    assign sel = decode(bus_req.addr);
    assign wr_ctrl = bus_req.wr && (sel == PWMDP_SEL_CTRL);
    assign wr_fifo = bus_req.wr && (sel == PWMDP_SEL_FIFO);
    assign fifo_clr = wr_ctrl && bus_req.wdata[PWMDP_CTL_CLR];

    // ==========================================================================
    // Registers
    logic [15:0] ctrl;
    logic [31:0] dma_cfg;
    logic [31:0] period [PWMDP_CH];
    logic [31:0] value [PWMDP_CH];
    pwmdp_chcfg_t cfg [PWMDP_CH];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= PWMDP_CTRL_RST;
            dma_cfg <= PWMDP_DMA_RST;
            period[0] <= PWMDP_PERIOD_RST;
            period[1] <= PWMDP_PERIOD_RST;
            value[0] <= PWMDP_VALUE_RST;
            value[1] <= PWMDP_VALUE_RST;
        end else if (bus_req.wr) begin
            unique case (sel)
                // The clear bit is a one-shot and is never stored.
                PWMDP_SEL_CTRL: ctrl <= bus_req.wdata[15:0] & ~(16'h0040);
                PWMDP_SEL_DMA: dma_cfg <= bus_req.wdata & 32'h8000FFFF;
                PWMDP_SEL_P1: period[0] <= bus_req.wdata;
                PWMDP_SEL_V1: value[0] <= bus_req.wdata;
                PWMDP_SEL_P2: period[1] <= bus_req.wdata;
                PWMDP_SEL_V2: value[1] <= bus_req.wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================================
    // Shared FIFO
    logic [PWMDP_DW-1:0] fifo_mem [PWMDP_FIFO_DEPTH];
    logic [PWMDP_PTR_W-1:0] fifo_wp;
    logic [PWMDP_PTR_W-1:0] fifo_rp;
    logic [PWMDP_LVL_W-1:0] fifo_lvl;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_push;
    logic fifo_pop;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [PWMDP_DW-1:0] buf_out_data;

    assign fifo_full = (fifo_lvl == PWMDP_LVL_W'(PWMDP_FIFO_DEPTH));
    assign fifo_empty = (fifo_lvl == '0);
    // A write while full is dropped; the DMA request can still be high then if its threshold exceeds 16.
    assign fifo_push = wr_fifo && !fifo_full;
    assign fifo_pop = !fifo_empty && buf_in_ready;

    always_ff @(posedge core_clk) begin
        if (fifo_push) begin
            fifo_mem[fifo_wp] <= bus_req.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fifo_wp <= '0;
            fifo_rp <= '0;
            fifo_lvl <= '0;
        end else if (fifo_clr) begin
            fifo_wp <= '0;
            fifo_rp <= '0;
            fifo_lvl <= '0;
        end else begin
            if (fifo_push) begin
                fifo_wp <= fifo_wp + 1'b1;
            end
            if (fifo_pop) begin
                fifo_rp <= fifo_rp + 1'b1;
            end
            fifo_lvl <= fifo_lvl + {4'h0, fifo_push} - {4'h0, fifo_pop};
        end
    end

    pwmdp_buf2 #(
        .W(PWMDP_DW)
    ) u_buf (
        .core_clk(core_clk),
        .rstn(rstn),
        .clr(fifo_clr),
        .in_valid(!fifo_empty),
        .in_ready(buf_in_ready),
        .in_data(fifo_mem[fifo_rp]),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // ==========================================================================
    // DMA requests
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dma_req <= 1'b0;
            dma_urgent <= 1'b0;
        end else begin
            dma_req <= dma_cfg[PWMDP_DMA_EN_BIT] &&
                ({3'h0, fifo_lvl} < dma_cfg[PWMDP_DRQ_LSB +: 8]);
            dma_urgent <= dma_cfg[PWMDP_DMA_EN_BIT] &&
                ({3'h0, fifo_lvl} < dma_cfg[PWMDP_URG_LSB +: 8]);
        end
    end

    // ==========================================================================
    // Word dispatch to sharing channels
    pwmdp_state_t st [PWMDP_CH];
    logic [PWMDP_CH-1:0] loaded;
    logic [PWMDP_CH-1:0] have_last;
    logic [PWMDP_CH-1:0] fifo_ch;
    logic [PWMDP_CH-1:0] grant;
    logic grant_pop;
    logic start_all;

    always_comb begin
        logic found;
        found = 1'b0;
        grant = '0;
        grant_pop = 1'b0;
        start_all = 1'b0;
        for (int i = 0; i < PWMDP_CH; i++) begin
            fifo_ch[i] = cfg[i].enable && cfg[i].fifo_select;
        end
        // The lowest waiting channel is served first, so each round hands out
        // words in channel order when the channels begin waiting together.
        for (int i = 0; i < PWMDP_CH; i++) begin
            if (!found && fifo_ch[i] && st[i] == PWMDP_NEED && !loaded[i]) begin
                found = 1'b1;
                if (buf_out_valid) begin
                    grant[i] = 1'b1;
                    grant_pop = 1'b1;
                end else if (cfg[i].repeat_last_word && have_last[i]) begin
                    grant[i] = 1'b1;
                end
            end
        end
        // All sharing channels start together once each holds a word.
        if (fifo_ch != '0) begin
            start_all = 1'b1;
            for (int i = 0; i < PWMDP_CH; i++) begin
                if (fifo_ch[i] && !(st[i] == PWMDP_NEED && loaded[i])) begin
                    start_all = 1'b0;
                end
            end
        end
    end

    assign buf_out_ready = grant_pop;

    // ==========================================================================
    // Channels
    logic [PWMDP_CH-1:0] running;

    genvar g;
    generate
        for (g = 0; g < PWMDP_CH; g++) begin : gen_ch
            logic [31:0] word;
            logic [31:0] cnt;
            logic [32:0] acc;
            logic [32:0] sum;
            logic period_end;
            logic next_bit;

            assign cfg[g] = '{
                enable: ctrl[g*PWMDP_CTL_STRIDE + PWMDP_CTL_EN],
                output_style_select: ctrl[g*PWMDP_CTL_STRIDE + PWMDP_CTL_MODE],
                repeat_last_word: ctrl[g*PWMDP_CTL_STRIDE + PWMDP_CTL_RPT],
                idle_level: ctrl[g*PWMDP_CTL_STRIDE + PWMDP_CTL_IDLE],
                fifo_select: ctrl[g*PWMDP_CTL_STRIDE + PWMDP_CTL_FIFO]
            };
            assign sum = acc + {1'b0, word};
            assign period_end = ({1'b0, cnt} + 33'h1) >= {1'b0, period[g]};

            always_comb begin
                if (cfg[g].output_style_select) begin
                    // MSB first; past bit 31 the idle level pads the tail.
                    if (cnt < 32'h20) begin
                        next_bit = word[5'h1F - cnt[4:0]];
                    end else begin
                        next_bit = cfg[g].idle_level;
                    end
                end else begin
                    next_bit = (sum >= {1'b0, period[g]});
                end
            end

            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    st[g] <= PWMDP_OFF;
                    word <= '0;
                    cnt <= '0;
                    acc <= '0;
                    loaded[g] <= 1'b0;
                    have_last[g] <= 1'b0;
                    pwm_out[g] <= 1'b0;
                end else if (!cfg[g].enable) begin
                    st[g] <= PWMDP_OFF;
                    loaded[g] <= 1'b0;
                    pwm_out[g] <= cfg[g].idle_level;
                end else begin
                    if (fifo_clr) begin
                        have_last[g] <= 1'b0;
                    end
                    unique case (st[g])
                        PWMDP_OFF: begin
                            pwm_out[g] <= cfg[g].idle_level;
                            cnt <= '0;
                            acc <= '0;
                            if (cfg[g].fifo_select) begin
                                st[g] <= PWMDP_NEED;
                            end else begin
                                word <= value[g];
                                st[g] <= PWMDP_RUN;
                            end
                        end
                        PWMDP_NEED: begin
                            // Waiting for the other sharing channels leaves a gap.
                            pwm_out[g] <= cfg[g].idle_level;
                            if (!cfg[g].fifo_select) begin
                                st[g] <= PWMDP_OFF;
                                loaded[g] <= 1'b0;
                            end else if (start_all) begin
                                st[g] <= PWMDP_RUN;
                                loaded[g] <= 1'b0;
                                cnt <= '0;
                                acc <= '0;
                            end else if (grant[g]) begin
                                if (grant_pop) begin
                                    word <= buf_out_data;
                                    have_last[g] <= 1'b1;
                                end
                                loaded[g] <= 1'b1;
                            end
                        end
                        PWMDP_RUN: begin
                            pwm_out[g] <= next_bit;
                            if (!cfg[g].output_style_select) begin
                                acc <= next_bit ? (sum - {1'b0, period[g]}) : sum;
                            end
                            if (period_end) begin
                                cnt <= '0;
                                acc <= '0;
                                if (cfg[g].fifo_select) begin
                                    st[g] <= PWMDP_NEED;
                                end else begin
                                    word <= value[g];
                                end
                            end else begin
                                cnt <= cnt + 32'h1;
                            end
                        end
                        default: st[g] <= PWMDP_OFF;
                    endcase
                end
            end

            assign running[g] = (st[g] == PWMDP_RUN);
        end
    endgenerate

    // ==========================================================================
    // Register read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= PWMDP_BUS_DEFAULT;
        end else if (bus_req.rd) begin
            unique case (sel)
                PWMDP_SEL_CTRL: bus_rdata <= {16'h0000, ctrl};
                PWMDP_SEL_STAT: begin
                    bus_rdata <= PWMDP_BUS_DEFAULT;
                    bus_rdata[PWMDP_STA_FULL] <= fifo_full;
                    bus_rdata[PWMDP_STA_EMPTY] <= fifo_empty;
                    bus_rdata[PWMDP_STA_RUN +: PWMDP_CH] <= running;
                    bus_rdata[PWMDP_STA_LVL +: PWMDP_LVL_W] <= fifo_lvl;
                end
                PWMDP_SEL_DMA: bus_rdata <= dma_cfg;
                PWMDP_SEL_P1: bus_rdata <= period[0];
                PWMDP_SEL_V1: bus_rdata <= value[0];
                PWMDP_SEL_P2: bus_rdata <= period[1];
                PWMDP_SEL_V2: bus_rdata <= value[1];
                PWMDP_SEL_FIFO: bus_rdata <= PWMDP_BUS_DEFAULT;
                default: bus_rdata <= PWMDP_BUS_DEFAULT;
            endcase
        end
    end

endmodule
`default_nettype wire

// ### testbench/pwmdp_chk.sv
// Port checker of the PWM channel data path.
`timescale 1ns/10ps
`default_nettype none
module pwmdp_chk
    import pwmdp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire pwmdp_req_t bus_req,
    input wire logic [PWMDP_DW-1:0] bus_rdata,
    input wire logic dma_req,
    input wire logic dma_urgent,
    input wire logic [PWMDP_CH-1:0] pwm_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ==========================================================================
    // Shadow registers
    logic [31:0] dma;
    logic [31:0] p1;
    logic [31:0] v1;
    logic [15:0] ctl;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dma <= PWMDP_DMA_RST;
            p1 <= PWMDP_PERIOD_RST;
            v1 <= PWMDP_VALUE_RST;
            ctl <= PWMDP_CTRL_RST;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                PWMDP_OFS_CTRL: ctl <= bus_req.wdata[15:0];
                PWMDP_OFS_DMA: dma <= bus_req.wdata & 32'h8000FFFF;
                PWMDP_OFS_P1: p1 <= bus_req.wdata;
                PWMDP_OFS_V1: v1 <= bus_req.wdata;
                default: ;
            endcase
        end
    end
    // ==========================================================================
    // Properties
    property p_req_off;
        !dma[31] |=> !dma_req;
    endproperty
    a_req_off: assert property (p_req_off) else $error("data request while disabled");
    property p_urg_off;
        !dma[31] |=> !dma_urgent;
    endproperty
    a_urg_off: assert property (p_urg_off) else $error("urgent request while disabled");
    property p_dma_rd;
        bus_req.rd && bus_req.addr == PWMDP_OFS_DMA |=> bus_rdata == $past(dma);
    endproperty
    a_dma_rd: assert property (p_dma_rd) else $error("dma config readback wrong");
    property p_p1_rd;
        bus_req.rd && bus_req.addr == PWMDP_OFS_P1 |=> bus_rdata == $past(p1);
    endproperty
    a_p1_rd: assert property (p_p1_rd) else $error("period readback wrong");
    property p_v1_rd;
        bus_req.rd && bus_req.addr == PWMDP_OFS_V1 |=> bus_rdata == $past(v1);
    endproperty
    a_v1_rd: assert property (p_v1_rd) else $error("value readback wrong");
    property p_fifo_rd;
        bus_req.rd && bus_req.addr == PWMDP_OFS_FIFO |=> bus_rdata == PWMDP_BUS_DEFAULT;
    endproperty
    a_fifo_rd: assert property (p_fifo_rd) else $error("fifo input readable");
    property p_hi_rd;
        bus_req.rd && bus_req.addr > PWMDP_OFS_V2 |=> bus_rdata == 32'h0;
    endproperty
    a_hi_rd: assert property (p_hi_rd) else $error("absent channel readable");
    // The output is registered behind the state, so four quiet cycles are allowed.
    property p_idle1;
        (!ctl[0] && !ctl[3]) [*4] |-> !pwm_out[0];
    endproperty
    a_idle1: assert property (p_idle1) else $error("channel 1 not idle");
    property p_idle2;
        (!ctl[8] && !ctl[11]) [*4] |-> !pwm_out[1];
    endproperty
    a_idle2: assert property (p_idle2) else $error("channel 2 not idle");
    c_req: cover property ($rose(dma_req));
    c_urg: cover property ($rose(dma_urgent));
    c_both: cover property (pwm_out[0] && pwm_out[1]);
endmodule
bind pwmdp_top pwmdp_chk pwmdp_chk_i (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .dma_req(dma_req), .dma_urgent(dma_urgent), .pwm_out(pwm_out));
`default_nettype wire

// ### testbench/pwmdp_dma_model.sv
// DMA controller model that feeds words into the shared FIFO input.
`timescale 1ns/10ps
`default_nettype none
module pwmdp_dma_model
    import pwmdp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic dma_req,
    output var pwmdp_req_t dma_bus
);
    // ==========================================================================
    // Word source
    // Requests are seen only at the falling edge, so the model overshoots by
    // the request latency just as a real controller would.
    always @(negedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dma_bus <= '0;
        end else if (go && dma_req) begin
            dma_bus.wr <= 1'b1;
            dma_bus.addr <= PWMDP_OFS_FIFO;
            dma_bus.wdata <= dma_bus.wdata + 32'h1;
        end else begin
            dma_bus.wr <= 1'b0;
            dma_bus.wdata <= ~dma_bus.wdata;
        end
    end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench of the PWM channel data path.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import pwmdp_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic dm_go = 1'b0;
    pwmdp_req_t tb_req = '0;
    pwmdp_req_t dm_req;
    pwmdp_req_t bus_req;
    logic [31:0] bus_rdata;
    logic dma_req;
    logic dma_urgent;
    logic [1:0] pwm_out;
    logic [31:0] w [4] = '{32'hA5000000, 32'hC3000000, 32'h81000000, 32'h99000000};
    int n_fail = 0;
    int cmp_count = 0;
    int hi;
    always #4 core_clk = ~core_clk;
    assign bus_req = dm_go ? dm_req : tb_req;
    pwmdp_top pwmdp_top_i (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .dma_req(dma_req), .dma_urgent(dma_urgent), .pwm_out(pwm_out));
    pwmdp_dma_model pwmdp_dma_model_i (.core_clk(core_clk), .rstn(rstn), .go(dm_go),
        .dma_req(dma_req), .dma_bus(dm_req));
    // ==========================================================================
    // Tasks
    task automatic close_out();
        $display("TB: checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk);
        tb_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        tb_req <= '0;
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
        input string nm);
        @(negedge core_clk);
        tb_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge core_clk);
        tb_req <= '0;
        @(negedge core_clk);
        chk(nm, exp, bus_rdata & m);
    endtask
    // Channel 1 is stopped first so that the new period and value load together.
    task automatic chan(input logic [31:0] p, input logic [31:0] v, input logic [15:0] c,
        input int n, output int h);
        int kk;
        wr(PWMDP_OFS_CTRL, 32'h0);
        wr(PWMDP_OFS_P1, p);
        wr(PWMDP_OFS_V1, v);
        wr(PWMDP_OFS_CTRL, {16'h0, c});
        // One cycle in the off state, then the first bit stands after the next edge.
        repeat (2) @(negedge core_clk);
        h = 0;
        for (int k = 0; k < n; k++) begin
            kk = k % p;
            if (c[1]) begin
                chk("serial bit", (kk < 32) ? v[31-kk] : c[3], pwm_out[0]);
            end
            h += (pwm_out[0] === 1'b1);
            @(negedge core_clk);
        end
    endtask
    task automatic frame(input logic [31:0] a, input logic [31:0] b);
        int t;
        t = 0;
        while (pwm_out[0] !== 1'b1 && t < 60) begin
            @(negedge core_clk);
            t++;
        end
        for (int k = 0; k < 8; k++) begin
            chk("shared bits", {b[31-k], a[31-k]}, pwm_out);
            @(negedge core_clk);
        end
    endtask
    // ==========================================================================
    // Tests
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        rdm(PWMDP_OFS_DMA, 32'h00000707, 32'hFFFFFFFF, "dma reset");
        rdm(PWMDP_OFS_P1, 32'h00000020, 32'hFFFFFFFF, "period1 reset");
        rdm(PWMDP_OFS_V2, 32'h00000000, 32'hFFFFFFFF, "value2 reset");
        wr(PWMDP_OFS_P2, 32'h00000055);
        wr(8'h30, 32'h00000099);
        rdm(PWMDP_OFS_P2, 32'h00000055, 32'hFFFFFFFF, "period2");
        rdm(8'h30, 32'h00000000, 32'hFFFFFFFF, "channel3 period");
        chan(4, 2, 16'h0001, 8, hi);
        chk("pulses 2 of 4", 4, hi);
        chan(8, 3, 16'h0001, 16, hi);
        chk("pulses 3 of 8", 6, hi);
        chan(36, 32'h80000001, 16'h000B, 72, hi);
        chan(4, 32'hA0000000, 16'h0003, 8, hi);
        rdm(PWMDP_OFS_V1, 32'hA0000000, 32'hFFFFFFFF, "value1");
        wr(PWMDP_OFS_CTRL, 32'h0);
        wr(PWMDP_OFS_DMA, 32'h00000304);
        repeat (3) @(negedge core_clk);
        chk("request disabled", 1'b0, dma_req);
        wr(PWMDP_OFS_DMA, 32'h80000304);
        repeat (2) @(negedge core_clk);
        chk("request on", 1'b1, dma_req);
        chk("urgent on", 1'b1, dma_urgent);
        dm_go <= 1'b1;
        repeat (20) @(negedge core_clk);
        dm_go <= 1'b0;
        chk("request met", 1'b0, dma_req);
        chk("urgent met", 1'b0, dma_urgent);
        wr(PWMDP_OFS_DMA, 32'h00000304);
        for (int i = 0; i < 20; i++) begin
            wr(PWMDP_OFS_FIFO, i);
        end
        rdm(PWMDP_OFS_STAT, 32'h00001001, 32'h00001F03, "fifo full");
        rdm(PWMDP_OFS_FIFO, 32'h00000000, 32'hFFFFFFFF, "fifo read");
        wr(PWMDP_OFS_P1, 32'h00000008);
        wr(PWMDP_OFS_P2, 32'h00000008);
        wr(PWMDP_OFS_CTRL, 32'h00002363);
        for (int i = 0; i < 4; i++) begin
            wr(PWMDP_OFS_FIFO, w[i]);
        end
        frame(w[0], w[1]);
        frame(w[2], w[3]);
        wr(PWMDP_OFS_CTRL, 32'h00000040);
        rdm(PWMDP_OFS_STAT, 32'h00000002, 32'h00001F03, "fifo empty");
        close_out();
    end
endmodule
`default_nettype wire
